// >>> verilog/mcps_parser.sv
`timescale 1ns/1ps
module mcps_parser #(
	parameter int NUM_AXES = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [7:0] in_char,
	input wire logic store_prog,
	input wire mcps_pkg::mcps_axis_flags_s [7:0] axis_flags,
	input wire mcps_pkg::mcps_plane_flags_s [1:0] plane_flags,
	input wire logic signed [7:0] [31:0] tell_vel,
	input wire logic signed [7:0] [15:0] drive_code,
	input wire logic signed [7:0] [15:0] adc_code,
	output logic cmd_valid,
	output mcps_pkg::mcps_cmd_s cmd,
	output logic [7:0] [31:0] axis_value,
	output logic bin_valid,
	output logic [7:0] bin_code,
	output logic reply_valid,
	output logic [7:0] reply_char,
	output logic [7:0] [15:0] axis_status,
	output logic [1:0] [15:0] plane_status,
	output logic signed [7:0] [31:0] rec_vel,
	output logic signed [7:0] [15:0] rec_torque,
	output logic signed [7:0] [15:0] rec_analog
);
	typedef struct packed {
		mcps_pkg::mcps_state_e st;
		logic [15:0] code;
		logic [2:0] nf;
		logic [31:0] acc;
		logic neg;
		logic dig;
		logic fq;
		logic bad;
		logic listm;
		logic [1:0] lcnt;
		logic [2:0] lidx;
		logic asg;
		logic [2:0] aidx;
		logic [7:0] amask;
		logic [1:0] pmask;
		logic [7:0] smask;
		logic [7:0] qmask;
		logic [7:0] [31:0] stage;
		logic [7:0] [31:0] vals;
		logic cmd_valid;
		mcps_pkg::mcps_cmd_s cmd;
		logic bin_valid;
		logic [7:0] bin_code;
		logic reply_valid;
		logic [7:0] reply_char;
		logic [7:0] [15:0] axis_status;
		logic [1:0] [15:0] plane_status;
		logic signed [7:0] [31:0] rec_vel;
		logic signed [7:0] [15:0] rec_torque;
		logic signed [7:0] [15:0] rec_analog;
	} mcps_regs_s;

	mcps_regs_s r;
	mcps_regs_s next_r;

	// letter to axis: {axis ok, plane ok, index}; aliases X Y Z W fold onto A B C D
	function automatic logic [4:0] axis_of(input logic [7:0] c);
		logic [4:0] res;
		res = 5'h00;
		if (c >= mcps_pkg::CH_A && c <= 8'h48) begin
			res = {1'b1, 1'b0, c[2:0] - 3'h1};
		end
		case (c)
			8'h58: res = {2'b10, 3'h0};
			8'h59: res = {2'b10, 3'h1};
			8'h5a: res = {2'b10, 3'h2};
			8'h57: res = {2'b10, 3'h3};
			8'h53: res = {2'b01, 3'h0};
			8'h54: res = {2'b01, 3'h1};
			default: ;
		endcase
		if (res[4] && {29'h0, res[2:0]} >= NUM_AXES) begin
			res[4] = 1'b0;
		end
		return res;
	endfunction

	function automatic logic is_upper(input logic [7:0] c);
		return c >= mcps_pkg::CH_A && c <= mcps_pkg::CH_Z;
	endfunction

	logic [7:0] c;
	logic term;
	logic [4:0] ax;
	logic [7:0] dv;
	assign c = in_char;
	assign term = c == mcps_pkg::CH_SEMI || c == mcps_pkg::CH_CR;
	assign ax = axis_of(c);
	assign dv = c - mcps_pkg::CH_ZERO;

	// one character per valid cycle; fields commit on comma or terminator
	always_comb begin
		logic fbad;
		logic [7:0] all;
		fbad = 1'b0;
		all = 8'hff >> (8 - NUM_AXES);
		next_r = r;
		next_r.cmd_valid = 1'b0;
		next_r.bin_valid = 1'b0;
		next_r.reply_valid = 1'b0;
		// status and record scaling run every cycle, independent of parsing
		for (int i = 0; i < 8; i++) begin
			next_r.axis_status[i] = axis_flags[i];
			next_r.rec_vel[i] = tell_vel[i] <<< mcps_pkg::VEL_SHIFT;
			// elements of a packed array are unsigned, so compare as signed on purpose
			if ($signed(drive_code[i]) > mcps_pkg::TORQUE_MAX) begin
				next_r.rec_torque[i] = mcps_pkg::TORQUE_MAX;
			end else if ($signed(drive_code[i]) < -mcps_pkg::TORQUE_MAX) begin
				next_r.rec_torque[i] = -mcps_pkg::TORQUE_MAX;
			end else begin
				next_r.rec_torque[i] = drive_code[i];
			end
			next_r.rec_analog[i] = adc_code[i];
		end
		for (int p = 0; p < 2; p++) begin
			next_r.plane_status[p] = {plane_flags[p].move, 9'h000, plane_flags[p].slewing,
				plane_flags[p].stopping, plane_flags[p].final_decel, 3'h0};
		end
		if (in_valid) begin
			case (r.st)
				mcps_pkg::MCPS_IDLE: begin
					next_r.bad = 1'b0;
					next_r.nf = 3'h0;
					next_r.acc = mcps_pkg::RST_VALUE;
					{next_r.neg, next_r.dig, next_r.fq, next_r.listm, next_r.asg} = 5'h00;
					next_r.lcnt = 2'h0;
					{next_r.amask, next_r.smask, next_r.qmask} = 24'h000000;
					next_r.pmask = 2'h0;
					if (c >= mcps_pkg::BIN_CODE_MIN) begin
						next_r.bin_valid = !store_prog;
						next_r.bin_code = c;
						if (store_prog) begin
							next_r.reply_valid = 1'b1;
							next_r.reply_char = mcps_pkg::CH_QUERY;
						end
					end else if (is_upper(c)) begin
						next_r.code[15:8] = c;
						next_r.st = mcps_pkg::MCPS_SECOND;
					end else if (!term && c != mcps_pkg::CH_SPACE) begin
						next_r.st = mcps_pkg::MCPS_DRAIN;
					end
				end
				mcps_pkg::MCPS_SECOND: begin
					if (is_upper(c)) begin
						next_r.code[7:0] = c;
						next_r.st = mcps_pkg::MCPS_ARGS;
					end else if (term) begin
						next_r.reply_valid = 1'b1;
						next_r.reply_char = mcps_pkg::CH_QUERY;
						next_r.st = mcps_pkg::MCPS_IDLE;
					end else begin
						next_r.st = mcps_pkg::MCPS_DRAIN;
					end
				end
				mcps_pkg::MCPS_ARGS: begin
					if (c == mcps_pkg::CH_SPACE) begin
						next_r.st = r.st;
					end else if (c >= mcps_pkg::CH_ZERO && c <= mcps_pkg::CH_NINE) begin
						fbad = (r.listm && !r.asg) || r.fq;
						next_r.acc = 32'(r.acc * 10) + {24'h0, dv};
						next_r.dig = 1'b1;
					end else if (c == mcps_pkg::CH_MINUS) begin
						fbad = r.dig || r.neg || r.fq || (r.listm && !r.asg);
						next_r.neg = 1'b1;
					end else if (c == mcps_pkg::CH_QUERY) begin
						fbad = r.dig || r.neg || r.fq || r.listm;
						next_r.fq = 1'b1;
					end else if (c == mcps_pkg::CH_EQ) begin
						// single-axis form needs exactly one plain axis letter first
						fbad = !r.listm || r.asg || r.lcnt != 2'h1 || r.pmask != 2'h0;
						next_r.asg = 1'b1;
						next_r.aidx = r.lidx;
					end else if (c == mcps_pkg::CH_COMMA || term) begin
						if (!r.listm) begin
							if (r.neg && !r.dig) begin
								fbad = 1'b1;
							end else if ((r.fq || r.dig) && {29'h0, r.nf} >= NUM_AXES) begin
								fbad = 1'b1;
							end else if (r.fq) begin
								next_r.qmask[r.nf] = 1'b1;
							end else if (r.dig) begin
								next_r.smask[r.nf] = 1'b1;
								next_r.stage[r.nf] = r.neg ? 32'(-r.acc) : r.acc;
							end
							next_r.nf = r.nf + 3'h1;
							fbad = fbad || (c == mcps_pkg::CH_COMMA && r.nf == 3'h7);
						end else if (r.asg) begin
							fbad = c == mcps_pkg::CH_COMMA || !r.dig;
							next_r.smask = 8'h01 << r.aidx;
							next_r.stage[r.aidx] = r.neg ? 32'(-r.acc) : r.acc;
						end else begin
							fbad = c == mcps_pkg::CH_COMMA || r.fq;
						end
						{next_r.acc, next_r.neg, next_r.dig, next_r.fq} = 35'h0;
					end else if (ax[4] || ax[3]) begin
						fbad = r.dig || r.neg || r.fq || r.nf != 3'h0 || r.asg;
						next_r.listm = 1'b1;
						if (r.lcnt != 2'h3) begin
							next_r.lcnt = r.lcnt + 2'h1;
						end
						next_r.lidx = ax[2:0];
						if (ax[4]) begin
							next_r.amask[ax[2:0]] = 1'b1;
						end else begin
							next_r.pmask[ax[0]] = 1'b1;
						end
					end else begin
						fbad = 1'b1;
					end
					next_r.bad = r.bad || fbad;
					if (term) begin
						next_r.st = mcps_pkg::MCPS_IDLE;
						next_r.reply_valid = 1'b1;
						if (r.bad || fbad) begin
							next_r.reply_char = mcps_pkg::CH_QUERY;
						end else begin
							next_r.reply_char = mcps_pkg::CH_COLON;
							next_r.cmd_valid = 1'b1;
							next_r.cmd.code = r.code;
							next_r.cmd.plane_mask = next_r.pmask;
							next_r.cmd.set_mask = next_r.smask;
							next_r.cmd.query_mask = next_r.qmask;
							next_r.cmd.stored = store_prog;
							next_r.cmd.axis_mask = next_r.amask;
							if (!r.listm && next_r.smask == 8'h00 && next_r.qmask == 8'h00
									&& r.nf == 3'h0) begin
								next_r.cmd.axis_mask = all;
							end
							for (int i = 0; i < 8; i++) begin
								if (next_r.smask[i]) begin
									next_r.vals[i] = next_r.stage[i];
								end
							end
						end
					end
				end
				mcps_pkg::MCPS_DRAIN: begin
					// swallow the rest of a bad instruction so its tail is not reparsed
					if (term) begin
						next_r.reply_valid = 1'b1;
						next_r.reply_char = mcps_pkg::CH_QUERY;
						next_r.st = mcps_pkg::MCPS_IDLE;
					end
				end
				default: next_r.st = mcps_pkg::MCPS_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign cmd_valid = r.cmd_valid;
	assign cmd = r.cmd;
	assign axis_value = r.vals;
	assign bin_valid = r.bin_valid;
	assign bin_code = r.bin_code;
	assign reply_valid = r.reply_valid;
	assign reply_char = r.reply_char;
	assign axis_status = r.axis_status;
	assign plane_status = r.plane_status;
	assign rec_vel = r.rec_vel;
	assign rec_torque = r.rec_torque;
	assign rec_analog = r.rec_analog;

	default clocking dc @(posedge mclk); endclocking
	default disable iff (rst);

	a_term_replies: assert property (in_valid && term && r.st == mcps_pkg::MCPS_ARGS
		|=> reply_valid) else $error("terminator gave no reply");
	a_reply_char: assert property (reply_valid |-> reply_char == mcps_pkg::CH_COLON
		|| reply_char == mcps_pkg::CH_QUERY) else $error("bad reply char");
	a_cmd_colon: assert property (cmd_valid |-> reply_valid
		&& reply_char == mcps_pkg::CH_COLON) else $error("command without colon");
	a_lower_drain: assert property (in_valid && r.st == mcps_pkg::MCPS_SECOND
		&& c >= 8'h61 && c <= 8'h7a |=> r.st == mcps_pkg::MCPS_DRAIN)
		else $error("lower case accepted");
	a_bin_detect: assert property (in_valid && r.st == mcps_pkg::MCPS_IDLE && c[7]
		&& !store_prog |=> bin_valid && bin_code == $past(in_char))
		else $error("binary code missed");
	a_bin_unstored: assert property (bin_valid |-> !$past(store_prog))
		else $error("binary accepted while storing");
	a_vel_scale: assert property (##1 rec_vel[0] ==
		($past(tell_vel[0]) <<< mcps_pkg::VEL_SHIFT))
		else $error("velocity scale wrong");
	a_torque_span: assert property ($signed(rec_torque[0]) <= mcps_pkg::TORQUE_MAX
		&& $signed(rec_torque[0]) >= -mcps_pkg::TORQUE_MAX)
		else $error("torque outside span");
	a_plane_unused: assert property ((plane_status[0] & 16'h7fc7) == 16'h0000)
		else $error("plane unused bit set");
	a_status_order: assert property (##1 axis_status[0][15] == $past(axis_flags[0].move)
		&& axis_status[0][0] == $past(axis_flags[0].motor_off))
		else $error("axis status order wrong");
	a_empty_keep: assert property (cmd_valid && !cmd.set_mask[0]
		|-> axis_value[0] == $past(axis_value[0])) else $error("empty field changed");
endmodule

// >>> include/mcps_pkg.sv
package mcps_pkg;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_QUERY = 8'h3f;
	localparam logic [7:0] CH_EQ = 8'h3d;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_Z = 8'h5a;
	localparam logic [7:0] BIN_CODE_MIN = 8'h80;
	localparam int VEL_SHIFT = 6;
	localparam logic signed [15:0] TORQUE_MAX = 16'sh7f20;
	localparam logic [7:0] RST_CHAR = 8'h00;
	localparam logic [31:0] RST_VALUE = 32'h0000_0000;

	typedef enum logic [2:0] {
		MCPS_IDLE = 3'b000,
		MCPS_SECOND = 3'b001,
		MCPS_ARGS = 3'b011,
		MCPS_DRAIN = 3'b010
	} mcps_state_e;

	typedef struct packed {
		logic [15:0] code;
		logic [7:0] axis_mask;
		logic [1:0] plane_mask;
		logic [7:0] set_mask;
		logic [7:0] query_mask;
		logic stored;
	} mcps_cmd_s;

	typedef struct packed {
		logic move;
		logic pos_mode;
		logic abs_only;
		logic find_edge;
		logic home;
		logic home_ph1;
		logic home_ph2;
		logic coord;
		logic neg_dir;
		logic contour;
		logic slewing;
		logic stopping;
		logic final_decel;
		logic latch_armed;
		logic off_on_err;
		logic motor_off;
	} mcps_axis_flags_s;

	typedef struct packed {
		logic move;
		logic slewing;
		logic stopping;
		logic final_decel;
	} mcps_plane_flags_s;
endpackage

// >>> tb/mcps_host.sv
`timescale 1ns/1ps
// host side of the character link: one character per cycle, back to back
module mcps_host (
	input wire logic mclk,
	output logic in_valid,
	output logic [7:0] in_char
);
	initial begin
		in_valid = 1'b0;
		in_char = 8'h00;
	end
	// each character stands for exactly one taking edge, then the line is scrambled
	// so that a stale byte can never pass for a fresh one between frames
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge mclk);
			#1;
			in_valid = 1'b1;
			in_char = s[i];
		end
		@(posedge mclk);
		#1;
		in_valid = 1'b0;
		in_char = ~in_char;
	endtask
endmodule

// >>> tb/mcps_parser_tb.sv
`timescale 1ns/1ps
module mcps_parser_tb;
	logic mclk, rst, store_prog, in_valid, cmd_valid, bin_valid, reply_valid;
	logic [7:0] in_char, bin_code, reply_char;
	mcps_pkg::mcps_axis_flags_s [7:0] axis_flags;
	mcps_pkg::mcps_plane_flags_s [1:0] plane_flags;
	logic [255:0] tell_vel, rec_vel;
	logic [127:0] drive_code, adc_code, rec_torque, rec_analog;
	mcps_pkg::mcps_cmd_s cmd;
	logic [7:0][31:0] axis_value;
	logic [7:0][15:0] axis_status;
	logic [1:0][15:0] plane_status;
	int bad_count = 0;
	int tests_run = 0;
	logic [15:0] lfsr = 16'h0048;

	mcps_host mcps_host_inst (.mclk(mclk), .in_valid(in_valid), .in_char(in_char));
	mcps_parser mcps_parser_inst (.mclk(mclk), .rst(rst), .in_valid(in_valid),
		.in_char(in_char), .store_prog(store_prog), .axis_flags(axis_flags),
		.plane_flags(plane_flags), .tell_vel(tell_vel), .drive_code(drive_code),
		.adc_code(adc_code), .cmd_valid(cmd_valid), .cmd(cmd), .axis_value(axis_value),
		.bin_valid(bin_valid), .bin_code(bin_code), .reply_valid(reply_valid),
		.reply_char(reply_char), .axis_status(axis_status), .plane_status(plane_status),
		.rec_vel(rec_vel), .rec_torque(rec_torque), .rec_analog(rec_analog));

	// 100 ns clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// torque saturates at +/-32544 (TORQUE_MAX) rather than wrapping
	function automatic logic [15:0] clamp_t(input logic signed [15:0] v);
		if (v > 16'sd32544) return 16'sd32544;
		if (v < -16'sd32544) return -16'sd32544;
		return v;
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// send one instruction, wait a bounded time for the reply, check reply and strobe
	task automatic run(input string s, input logic [7:0] rc, input logic cv);
		mcps_host_inst.send(s);
		for (int k = 0; k < 4 && reply_valid !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
		cmp(reply_char, rc);
		cmp(cmd_valid, cv);
	endtask

	// a hang costs a mismatch and ends the run the usual way
	initial begin
		#1_000_000;
		bad_count++;
		conclude();
	end

	initial begin
		string b;
		logic [31:0] v;
		logic [15:0] e;
		mcps_pkg::mcps_axis_flags_s f;
		rst = 1'b1;
		store_prog = 1'b0;
		axis_flags = '0;
		plane_flags = '0;
		tell_vel = '0;
		drive_code = '0;
		adc_code = '0;
		repeat (4) @(posedge mclk);
		#1;
		rst = 1'b0;
		run("BG;", mcps_pkg::CH_COLON, 1'b1);
		cmp(cmd.code, 16'h4247);
		cmp({cmd.axis_mask, 7'h00, cmd.stored}, 16'hff00);
		run("PR 7,,3;", mcps_pkg::CH_COLON, 1'b1);
		run("PR ,5;", mcps_pkg::CH_COLON, 1'b1);
		cmp(cmd.set_mask, 8'h02);
		cmp({axis_value[0], axis_value[1]}, {32'd7, 32'd5});
		cmp(axis_value[2], 32'd3);
		run("PR?,,?;", mcps_pkg::CH_COLON, 1'b1);
		cmp({cmd.query_mask, cmd.set_mask}, 16'h0500);
		cmp(axis_value[0], 32'd7);
		run("ACY=-12;", mcps_pkg::CH_COLON, 1'b1);
		cmp({cmd.code, cmd.set_mask}, 24'h414302);
		cmp(axis_value[1], 32'hfffffff4);
		run("BG XWS;", mcps_pkg::CH_COLON, 1'b1);
		cmp({cmd.plane_mask, cmd.axis_mask}, {2'b01, 8'h09});
		run("ST TE\015", mcps_pkg::CH_COLON, 1'b1);
		cmp({cmd.plane_mask, cmd.axis_mask}, {2'b10, 8'h10});
		$display("test syntax done");
		run("bg;", mcps_pkg::CH_QUERY, 1'b0);
		run("PR 1a;", mcps_pkg::CH_QUERY, 1'b0);
		cmp(axis_value[0], 32'd7);
		for (int r = 0; r < 4; r++) begin
			lfsr = nxt(lfsr);
			v = {18'h0, lfsr[13:0]};
			run($sformatf("PR %0d;", v), mcps_pkg::CH_COLON, 1'b1);
			cmp(axis_value[0], v);
		end
		$display("test refusals and numbers done");
		b = " ";
		b[0] = 8'ha7;
		mcps_host_inst.send(b);
		for (int k = 0; k < 4 && bin_valid !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
		cmp({bin_valid, bin_code}, 9'h1a7);
		store_prog = 1'b1;
		run(b, mcps_pkg::CH_QUERY, 1'b0);
		run("BG;", mcps_pkg::CH_COLON, 1'b1);
		cmp(cmd.stored, 1'b1);
		store_prog = 1'b0;
		$display("test binary and stored done");
		for (int r = 0; r < 5; r++) begin
			for (int i = 0; i < 8; i++) begin
				lfsr = nxt(lfsr);
				axis_flags[i] = lfsr;
				tell_vel[32*i +: 32] = {{16{lfsr[15]}}, lfsr};
				lfsr = nxt(lfsr);
				drive_code[16*i +: 16] = lfsr;
				adc_code[16*i +: 16] = ~lfsr;
			end
			plane_flags = lfsr[7:0];
			if (r == 0) begin
				drive_code[31:0] = 32'h7fff_8000; // both saturation corners
			end
			repeat (2) @(posedge mclk);
			#1;
			for (int i = 0; i < 8; i++) begin
				f = axis_flags[i];
				e = {f.move, f.pos_mode, f.abs_only, f.find_edge, f.home, f.home_ph1,
					f.home_ph2, f.coord, f.neg_dir, f.contour, f.slewing, f.stopping,
					f.final_decel, f.latch_armed, f.off_on_err, f.motor_off};
				cmp(axis_status[i], e);
				cmp(rec_vel[32*i +: 32], tell_vel[32*i +: 32] * 64);
				cmp(rec_torque[16*i +: 16], clamp_t(drive_code[16*i +: 16]));
				cmp(rec_analog[16*i +: 16], adc_code[16*i +: 16]);
			end
			for (int p = 0; p < 2; p++) begin
				e = {plane_flags[p].move, 9'h000, plane_flags[p].slewing,
					plane_flags[p].stopping, plane_flags[p].final_decel, 3'h0};
				cmp(plane_status[p], e);
			end
		end
		$display("test status and record done");
		conclude();
	end
endmodule
